// ===== ascc_top.v
// How it works
// - Mode zero: clock pin is flip control
// - Mode zero: data pin is USB switch
// - Strap mode: enable pin gates DisplayPort
// - Otherwise DisplayPort follows I2C register bit
// - Otherwise enable pin is hot-plug input
// - Hot-plug low over 2 ms kills lanes
// - AUX routed to SBU1/SBU2 by orientation
// - Display EQ from two display straps
// - Upstream EQ from two upstream straps
// - Non-zero mode: EQ straps form address
// - Mode strap decode: strap/test/1.8V/3.3V
// - Strap mode hot-plug input also times out
`timescale 1ns/1ps
`default_nettype none
`include "ascc_defs.vh"

module ascc_top (
  // Clock and reset
  input  wire       mclk_in,
  input  wire       resetn_in,
  // Four-level straps
  input  wire [1:0] mode_strap_in,
  input  wire [1:0] display_eq_sel_lo_in,
  input  wire [1:0] display_eq_sel_hi_in,
  input  wire [1:0] upstream_eq_sel_lo_in,
  input  wire [1:0] upstream_eq_sel_hi_in,
  // Shared control pins
  input  wire       clk_pin_in,
  input  wire       data_pin_in,
  input  wire       display_enable_ctl_in,
  input  wire       hot_plug_in,
  // From I2C register file
  input  wire       i2c_dp_enable_in,
  input  wire       i2c_flip_in,
  input  wire       i2c_usb_enable_in,
  // Mode and pin routing
  output reg  [1:0] mode_out,
  output reg        i2c_active_out,
  output reg        i2c_scl_out,
  output reg        i2c_sda_out,
  output reg        straps_valid_out,
  // Switch control
  output reg        flip_out,
  output reg        usb_switch_ctl_out,
  output reg        dp_enable_out,
  output reg        dp_lanes_on_out,
  output reg        aux_sbu_closed_out,
  output reg        aux_to_sbu1_out,
  output reg        aux_to_sbu2_out,
  // Equalization and address
  output reg  [3:0] display_eq_out,
  output reg  [3:0] upstream_eq_out,
  output reg        target_addr_bit_lo_out,
  output reg        target_addr_bit_hi_out,
  output reg  [1:0] target_addr_lvl_lo_out,
  output reg  [1:0] target_addr_lvl_hi_out,
  output reg        addr_strap_fault_out
);

  // ----------------------------------------
  // Strap latch
  // ----------------------------------------
  // Straps are sampled on the third cycle after release so pins settle
  reg [1:0] wait_cnt;
  reg       latched;
  reg [1:0] mode_q;
  reg [1:0] deq_lo;
  reg [1:0] deq_hi;
  reg [1:0] ueq_lo;
  reg [1:0] ueq_hi;

  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      wait_cnt <= 2'h0;
      latched  <= 1'b0;
      mode_q   <= 2'h0;
      deq_lo   <= 2'h0;
      deq_hi   <= 2'h0;
      ueq_lo   <= 2'h0;
      ueq_hi   <= 2'h0;
    end else if (!latched) begin
      if (wait_cnt == `ASCC_LATCH_WAIT) begin
        latched <= 1'b1;
        mode_q  <= mode_strap_in;
        deq_lo  <= display_eq_sel_lo_in;
        deq_hi  <= display_eq_sel_hi_in;
        ueq_lo  <= upstream_eq_sel_lo_in;
        ueq_hi  <= upstream_eq_sel_hi_in;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  reg [1:0] next_mode;
  wire      strap_mode = latched && (mode_q == `ASCC_LVL_ZERO);

  always @* begin
    case (mode_q)
      `ASCC_LVL_ZERO: next_mode = `ASCC_MODE_STRAP;
      `ASCC_LVL_R:    next_mode = `ASCC_MODE_TEST;
      `ASCC_LVL_F:    next_mode = `ASCC_MODE_I2C18;
      `ASCC_LVL_ONE:  next_mode = `ASCC_MODE_I2C33;
      default:        next_mode = `ASCC_MODE_STRAP;
    endcase
  end

  // ----------------------------------------
  // Hot-plug timing
  // ----------------------------------------
  // Separate pin in strap mode, shared enable pin otherwise
  wire hpd_level = strap_mode ? hot_plug_in : display_enable_ctl_in;
  wire hpd_lost;

  ascc_low_timer #(
    .LIMIT (`ASCC_HPD_LOW_CYC)
  ) u_hpd_timer (
    .mclk_in      (mclk_in),
    .resetn_in    (resetn_in),
    .level_in     (hpd_level),
    .low_long_out (hpd_lost)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Everything holds safe values until the straps are latched
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      mode_out               <= 2'h0;
      i2c_active_out         <= 1'b0;
      i2c_scl_out            <= 1'b1;
      i2c_sda_out            <= 1'b1;
      straps_valid_out       <= 1'b0;
      flip_out               <= 1'b0;
      usb_switch_ctl_out     <= 1'b0;
      dp_enable_out          <= 1'b0;
      dp_lanes_on_out        <= 1'b0;
      aux_sbu_closed_out     <= 1'b0;
      aux_to_sbu1_out        <= 1'b0;
      aux_to_sbu2_out        <= 1'b0;
      display_eq_out         <= 4'h0;
      upstream_eq_out        <= 4'h0;
      target_addr_bit_lo_out <= 1'b0;
      target_addr_bit_hi_out <= 1'b0;
      target_addr_lvl_lo_out <= 2'h0;
      target_addr_lvl_hi_out <= 2'h0;
      addr_strap_fault_out   <= 1'b0;
    end else if (latched) begin
      mode_out         <= next_mode;
      straps_valid_out <= 1'b1;
      i2c_active_out   <= !strap_mode;
      if (strap_mode) begin
        flip_out           <= clk_pin_in;
        usb_switch_ctl_out <= data_pin_in;
        dp_enable_out      <= display_enable_ctl_in;
        i2c_scl_out        <= 1'b1;
        i2c_sda_out        <= 1'b1;
        target_addr_bit_lo_out <= 1'b0;
        target_addr_bit_hi_out <= 1'b0;
      end else begin
        i2c_scl_out        <= clk_pin_in;
        i2c_sda_out        <= data_pin_in;
        flip_out           <= i2c_flip_in;
        usb_switch_ctl_out <= i2c_usb_enable_in;
        dp_enable_out      <= i2c_dp_enable_in;
        // Address bit is set by any non-zero strap level
        target_addr_bit_lo_out <= (ueq_lo != `ASCC_LVL_ZERO);
        target_addr_bit_hi_out <= (deq_lo != `ASCC_LVL_ZERO);
      end
      target_addr_lvl_lo_out <= strap_mode ? 2'h0 : ueq_lo;
      target_addr_lvl_hi_out <= strap_mode ? 2'h0 : deq_lo;
      // Flags a board that breaks the 1.8 V address strap limit
      addr_strap_fault_out <= (mode_q == `ASCC_LVL_F) &&
                              (ueq_lo != `ASCC_LVL_F) &&
                              (ueq_lo != `ASCC_LVL_ZERO);
      // Lanes drop on hot-plug loss, AUX switch stays closed
      dp_lanes_on_out    <= (strap_mode ? display_enable_ctl_in : i2c_dp_enable_in)
                            && !hpd_lost;
      aux_sbu_closed_out <= strap_mode ? display_enable_ctl_in : i2c_dp_enable_in;
      aux_to_sbu1_out    <= (strap_mode ? !clk_pin_in : !i2c_flip_in);
      aux_to_sbu2_out    <= (strap_mode ? clk_pin_in : i2c_flip_in);
      display_eq_out     <= {deq_hi, deq_lo};
      upstream_eq_out    <= {ueq_hi, ueq_lo};
    end
  end

endmodule
`default_nettype wire

// ===== ascc_defs.vh
`ifndef ASCC_DEFS_VH
`define ASCC_DEFS_VH

// ----------------------------------------
// Four-level strap encodings
// ----------------------------------------
`define ASCC_LVL_ZERO   2'h0
`define ASCC_LVL_R      2'h1
`define ASCC_LVL_F      2'h2
`define ASCC_LVL_ONE    2'h3

// ----------------------------------------
// Mode decode outputs
// ----------------------------------------
`define ASCC_MODE_STRAP 2'h0
`define ASCC_MODE_TEST  2'h1
`define ASCC_MODE_I2C18 2'h2
`define ASCC_MODE_I2C33 2'h3

// ----------------------------------------
// Hot-plug low time
// ----------------------------------------
`define ASCC_CLK_HZ         25000000
`define ASCC_HPD_LOW_US     2000
// 2000 us at 25 MHz is 50000 cycles, sized to the 16-bit timer
`define ASCC_HPD_LOW_CYC    16'hc350
`define ASCC_CNT_W          16

// ----------------------------------------
// Latch sequencing
// ----------------------------------------
`define ASCC_LATCH_WAIT 2'h2

`endif

// ===== ascc_low_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ascc_defs.vh"

module ascc_low_timer #(
  parameter [`ASCC_CNT_W-1:0] LIMIT = 16'h0001
) (
  // Clock and reset
  input  wire                   mclk_in,
  input  wire                   resetn_in,
  // Monitored level
  input  wire                   level_in,
  // Result
  output reg                    low_long_out
);

  reg [`ASCC_CNT_W-1:0] count;

  // Count saturates so the flag stays set while the level stays low
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      count        <= {`ASCC_CNT_W{1'b0}};
      low_long_out <= 1'b0;
    end else if (level_in) begin
      count        <= {`ASCC_CNT_W{1'b0}};
      low_long_out <= 1'b0;
    end else if (count >= LIMIT) begin
      low_long_out <= 1'b1;
    end else begin
      count <= count + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// ===== ascc_props.sv
`timescale 1ns/1ps
`default_nettype none
module ascc_props (
  input wire logic       mclk_in, resetn_in, clk_pin_in, data_pin_in,
  input wire logic       display_enable_ctl_in, hot_plug_in, i2c_dp_enable_in,
  input wire logic [1:0] mode_out,
  input wire logic       i2c_active_out, straps_valid_out, flip_out, usb_switch_ctl_out,
  input wire logic       dp_enable_out, dp_lanes_on_out, aux_sbu_closed_out,
  input wire logic       aux_to_sbu1_out, aux_to_sbu2_out, target_addr_bit_lo_out,
  input wire logic [3:0] upstream_eq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Hot-plug source moves pins with the mode
  wire hp_line = (mode_out == 2'h0) ? hot_plug_in : display_enable_ctl_in;
  sequence up_s; straps_valid_out && $past(straps_valid_out); endsequence
  sequence hp_hi_s; (straps_valid_out && hp_line) [*4] ##0 !$rose(dp_enable_out); endsequence
  flip_sel_a: assert property (up_s ##0 mode_out == 2'h0 |=> flip_out == $past(clk_pin_in))
    else $error("flip wrong");
  usb_sel_a: assert property (up_s ##0 mode_out == 2'h0 |=> usb_switch_ctl_out == $past(data_pin_in))
    else $error("usb ctl wrong");
  dp_strap_a: assert property (up_s ##0 mode_out == 2'h0 |=> dp_enable_out == $past(display_enable_ctl_in))
    else $error("dp strap wrong");
  dp_i2c_a: assert property (up_s ##0 mode_out != 2'h0 |=> dp_enable_out == $past(i2c_dp_enable_in))
    else $error("dp i2c wrong");
  aux_route_a: assert property (up_s |-> aux_to_sbu2_out == flip_out && aux_to_sbu1_out != flip_out)
    else $error("aux route wrong");
  aux_closed_a: assert property (up_s |-> aux_sbu_closed_out == dp_enable_out)
    else $error("aux switch wrong");
  addr_bit_a: assert property (up_s ##0 i2c_active_out |-> target_addr_bit_lo_out == (upstream_eq_out[1:0] != 2'h0))
    else $error("addr bit wrong");
  strap_hold_a: assert property (up_s |-> $stable(mode_out) && $stable(upstream_eq_out))
    else $error("strap moved");
  mode_dec_a: assert property (up_s |-> i2c_active_out == (mode_out != 2'h0))
    else $error("mode decode wrong");
  hp_alive_a: assert property (hp_hi_s |-> dp_lanes_on_out || !dp_enable_out)
    else $error("lanes off with hot-plug high");
endmodule
bind ascc_top ascc_props u_props (.*);
`default_nettype wire

// ===== ascc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ascc_host (
  input  wire logic       mclk_in,
  input  wire logic [1:0] mode_req, addr_req,
  output var  logic [1:0] mode_strap = 2'h0, addr_strap = 2'h0
);
  always @(posedge mclk_in) begin
    mode_strap <= mode_req;
    // A 1.8 V bus only allows F or zero here
    addr_strap <= (mode_req == 2'h2 && addr_req != 2'h0) ? 2'h2 : addr_req;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       mclk_in = 1'b0, resetn_in = 1'b0, clk_pin_in = 1'b0, data_pin_in = 1'b0, f;
  logic       display_enable_ctl_in = 1'b1, hot_plug_in = 1'b1, i2c_dp_enable_in = 1'b0;
  logic       i2c_flip_in = 1'b0, i2c_usb_enable_in = 1'b0;
  logic [1:0] mreq = 2'h0, ulo = 2'h0, eul, display_eq_sel_lo_in = 2'h0;
  logic [1:0] display_eq_sel_hi_in = 2'h0, upstream_eq_sel_hi_in = 2'h0;
  wire  [1:0] mode_strap_in, upstream_eq_sel_lo_in, mode_out, target_addr_lvl_lo_out;
  wire  [1:0] target_addr_lvl_hi_out;
  wire  [3:0] display_eq_out, upstream_eq_out;
  wire        i2c_active_out, i2c_scl_out, i2c_sda_out, straps_valid_out, flip_out;
  wire        usb_switch_ctl_out, dp_enable_out, dp_lanes_on_out, aux_sbu_closed_out;
  wire        aux_to_sbu1_out, aux_to_sbu2_out, target_addr_bit_lo_out;
  wire        target_addr_bit_hi_out, addr_strap_fault_out;
  int         err_total = 0, n_tests = 0, w;
  ascc_top DUT (.*);
  ascc_host u_host (.mclk_in(mclk_in), .mode_req(mreq), .addr_req(ulo),
                    .mode_strap(mode_strap_in), .addr_strap(upstream_eq_sel_lo_in));
  initial forever #20 mclk_in = ~mclk_in;
  task tick(input int n); repeat (n) @(posedge mclk_in); endtask
  task chk(input string n, input logic [3:0] s, input logic [3:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // One reset per mode strap level
  // ----------------------------------------
  initial begin
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk_in);
      resetn_in <= 1'b0; mreq <= 2'(m); ulo <= 2'(m + 1);
      display_eq_sel_lo_in <= 2'(m); display_eq_sel_hi_in <= 2'(3 - m); upstream_eq_sel_hi_in <= 2'(m);
      tick(6);
      resetn_in <= 1'b1;
      w = 0;
      while (straps_valid_out !== 1'b1 && w < 20) begin tick(1); w++; end
      if (w == 20) begin err_total++; finish_test; end
      tick(2);
      eul = (m == 2) ? 2'h2 : 2'(m + 1);
      chk("mode", mode_out, 4'(m));
      chk("i2c", i2c_active_out, m != 0);
      chk("deq", display_eq_out, {2'(3 - m), 2'(m)});
      chk("ueq", upstream_eq_out, {2'(m), eul});
      chk("alo", target_addr_bit_lo_out, m != 0 && eul != 2'h0);
      chk("ahi", target_addr_bit_hi_out, m != 0);
      chk("flt", addr_strap_fault_out, 4'h0);
      chk("alvl", target_addr_lvl_lo_out, (m != 0) ? eul : 2'h0);
      chk("ahlvl", target_addr_lvl_hi_out, (m != 0) ? 2'(m) : 2'h0);
      for (int p = 0; p < 2; p++) begin
        @(posedge mclk_in);
        clk_pin_in <= p[0]; data_pin_in <= !p[0]; display_enable_ctl_in <= p[0];
        i2c_flip_in <= !p[0]; i2c_usb_enable_in <= p[0]; i2c_dp_enable_in <= !p[0];
        tick(3);
        f = (m != 0) ? !p[0] : p[0];
        chk("flip", flip_out, f);
        chk("sbu2", aux_to_sbu2_out, f);
        chk("sbu1", aux_to_sbu1_out, !f);
        chk("usb", usb_switch_ctl_out, (m != 0) ? p[0] : !p[0]);
        chk("dp", dp_enable_out, (m != 0) ? !p[0] : p[0]);
        chk("scl", i2c_scl_out, (m != 0) ? p[0] : 1'b1);
        chk("sda", i2c_sda_out, (m != 0) ? !p[0] : 1'b1);
      end
      mreq <= 2'(m + 1);
      tick(4);
      chk("hold", mode_out, 4'(m));
    end
    // Mode one: enable pin now carries hot-plug, short lows must not trip
    i2c_dp_enable_in <= 1'b1; display_enable_ctl_in <= 1'b0;
    tick(100);
    display_enable_ctl_in <= 1'b1;
    tick(3);
    chk("lanes", dp_lanes_on_out, 4'h1);
    display_enable_ctl_in <= 1'b0;
    tick(50010);
    chk("lost", dp_lanes_on_out, 4'h0);
    chk("aux", aux_sbu_closed_out, 4'h1);
    display_enable_ctl_in <= 1'b1;
    tick(3);
    chk("back", dp_lanes_on_out, 4'h1);
    finish_test;
  end
endmodule
`default_nettype wire
